/* File: src/lsp_pkg.sv */
// package: shared constants and types of the length steered serial port
package lsp_pkg;
    // ==========================================================
    // frame lengths and register widths
    localparam int unsigned LSP_CFG_LEN   = 8;
    localparam int unsigned LSP_REF_LEN   = 16;
    localparam int unsigned LSP_MAIN_LEN  = 24;
    localparam int unsigned LSP_REF_DIV_W = 13;
    localparam int unsigned LSP_FB_DIV_W  = 18;
    localparam logic [5:0]  LSP_CNT_SAT   = 6'h21; // 33: longer frames never alias
    // ==========================================================
    // field positions
    localparam int unsigned LSP_SEL_HI_POS = 23;   // output_select_high
    localparam int unsigned LSP_SEL_LO_POS = 22;   // output_select_low
    localparam int unsigned LSP_PORT_POS   = 1;    // port_level_bit
    localparam int unsigned LSP_OD_POS     = 0;    // open_drain_level_bit
    localparam int unsigned LSP_N_LSB      = 6;    // 12-bit main count
    localparam int unsigned LSP_A_LSB      = 0;    // 6-bit swallow count
    localparam int unsigned LSP_N_W        = 12;
    localparam int unsigned LSP_A_W        = 6;
    // ==========================================================
    // output select codes
    localparam logic [1:0] LSP_SEL_PORT = 2'h0;
    localparam logic [1:0] LSP_SEL_DOUT = 2'h1;
    localparam logic [1:0] LSP_SEL_FB   = 2'h2;
    localparam logic [1:0] LSP_SEL_REF  = 2'h3;
    // ==========================================================
    // reset values
    localparam logic [7:0]  LSP_CFG_RST  = 8'h00;
    localparam logic [2:0]  LSP_MODE_RST = 3'h0;
    localparam logic [12:0] LSP_RDIV_RST = 13'h0000;
    localparam logic [23:0] LSP_MAIN_RST = 24'h400000; // data out selected
    // ==========================================================
    // types
    typedef enum logic [2:0] {
        LSP_ST_IDLE  = 3'b001,
        LSP_ST_SHIFT = 3'b010,
        LSP_ST_LOST  = 3'b100
    } lsp_state_e;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic frame_enable_n;
    } lsp_serial_s;
endpackage

/* File: src/lsp_pulse_div.sv */
// module: counts input ticks and emits one pulse per divisor ticks
`timescale 1ns/1ns
module lsp_pulse_div #(
    parameter int unsigned W = 13
) (
    input  wire logic         mclk,    // system clock
    input  wire logic         rstn,    // sync reset, active low
    input  wire logic         tick,    // one input edge
    input  wire logic [W-1:0] divisor, // divide ratio, 0 stops
    output logic              pulse    // one-cycle high pulse
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_pulse;

    // ==========================================================
    // divider: idles low, pulses high on the last tick of a period
    always_comb begin
        next_cnt   = cnt;
        next_pulse = 1'b0;
        if (tick && (divisor != '0)) begin
            if (cnt >= divisor - W'(1)) begin
                next_cnt   = '0;
                next_pulse = 1'b1;
            end else begin
                next_cnt = cnt + W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt   <= '0;
            pulse <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            pulse <= next_pulse;
        end
    end

    a_div_idle: assert property (@(posedge mclk) disable iff (!rstn)
        !tick |=> !pulse) else $error("divider pulsed without a tick");
endmodule // lsp_pulse_div

/* File: src/lsp_serial_port.sv */
// module: serial control port with length steered register commit
`timescale 1ns/1ns
// Operation
// - sample data on rising clock, MSB first
// - bit count picks target register
// - registers stay unchanged while shifting
// - enable rising edge commits shifted word
// - 16-bit frame: 13 bits buffered, mode immediate
// - 24-bit frame also moves reference buffer
// - empty enable pulse moves reference buffer
// - no address bits, any write order
// - shift tail out on falling clock
// - enable high ignores clock, port initialized
// - no enable toggle at clock high; resync
// - select bits route configurable output
// - reference divider pulse, ratio 1 passes
// - feedback divider pulse, ratio N*64+A
// - power-up selects serial data out
// - port mode drives port level bit
// - open drain follows its level bit
// - reset drives open drain low
module lsp_serial_port (
    input  wire logic                 mclk,            // 10 MHz system clock
    input  wire logic                 rstn,            // sync reset, active low
    input  wire lsp_pkg::lsp_serial_s serial_pins,     // clock, data, frame enable
    input  wire logic                 reference_input, // reference pin
    input  wire logic                 rf_input,        // prescaled rf pin
    output logic                      config_out,      // configurable output
    output logic                      open_drain_out,  // open drain level, always 0
    output logic                      open_drain_oe    // high while pulling low
);
    import lsp_pkg::*;

    // ==========================================================
    // pin synchronisers
    localparam int unsigned NSYNC = 5;
    localparam logic [NSYNC-1:0] SYNC_RST = 5'h04; // enable idles high: no false edge
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] meta;
    logic [NSYNC-1:0] sync;
    logic [NSYNC-1:0] prev;

    assign raw = {rf_input, reference_input, serial_pins.frame_enable_n,
                  serial_pins.sdata, serial_pins.sclk};

    // two flops per pin; prev only feeds edge detection
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    meta[gi] <= SYNC_RST[gi];
                    sync[gi] <= SYNC_RST[gi];
                    prev[gi] <= SYNC_RST[gi];
                end else begin
                    meta[gi] <= raw[gi];
                    sync[gi] <= meta[gi];
                    prev[gi] <= sync[gi];
                end
            end
        end
    endgenerate

    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic sdata_lvl;
    logic fen_n_lvl;
    logic fen_rise;
    logic fen_fall;
    logic ref_tick;
    logic rf_tick;

    assign sclk_lvl  = sync[0];
    assign sclk_rise = sync[0] & ~prev[0];
    assign sclk_fall = ~sync[0] & prev[0];
    assign sdata_lvl = sync[1];
    assign fen_n_lvl = sync[2];
    assign fen_rise  = sync[2] & ~prev[2];
    assign fen_fall  = ~sync[2] & prev[2];
    assign ref_tick  = sync[3] & ~prev[3];
    assign rf_tick   = sync[4] & ~prev[4];

    // ==========================================================
    // frame length decode, shared by commit logic and checks
    function automatic logic [1:0] len_target(input logic [5:0] n);
        case (n)
            6'(LSP_CFG_LEN):  len_target = 2'h1;
            6'(LSP_REF_LEN):  len_target = 2'h2;
            6'(LSP_MAIN_LEN): len_target = 2'h3;
            default: len_target = 2'h0;
        endcase
    endfunction

    // ==========================================================
    // serial port state and registers
    lsp_state_e  state;
    lsp_state_e  next_state;
    logic [23:0] shift;
    logic [23:0] next_shift;
    logic [5:0]  count;
    logic [5:0]  next_count;
    logic        dout;
    logic        next_dout;
    logic [7:0]  cfg;
    logic [7:0]  next_cfg;
    logic [2:0]  ref_mode;
    logic [2:0]  next_ref_mode;
    logic [12:0] ref_buf1;
    logic [12:0] next_ref_buf1;
    logic [12:0] ref_buf2;
    logic [12:0] next_ref_buf2;
    logic [23:0] main_reg;
    logic [23:0] next_main_reg;
    logic        commit;

    // a commit needs a clean rise: enable must not move while clock is high
    assign commit = (state == LSP_ST_SHIFT) && fen_rise && !sclk_lvl;

    // next-state logic; registers change only on commit
    always_comb begin
        next_state    = state;
        next_shift    = shift;
        next_count    = count;
        next_dout     = dout;
        next_cfg      = cfg;
        next_ref_mode = ref_mode;
        next_ref_buf1 = ref_buf1;
        next_ref_buf2 = ref_buf2;
        next_main_reg = main_reg;
        case (state)
            LSP_ST_IDLE: begin
                // clock edges are ignored while enable is high
                next_count = '0;
                if (fen_fall) begin
                    next_state = sclk_lvl ? LSP_ST_LOST : LSP_ST_SHIFT;
                end
            end
            LSP_ST_SHIFT: begin
                if (fen_rise) begin
                    next_state = commit ? LSP_ST_IDLE : LSP_ST_LOST;
                end else begin
                    if (sclk_rise) begin
                        next_shift = {shift[22:0], sdata_lvl};
                        if (count != LSP_CNT_SAT) begin
                            next_count = count + 6'h01;
                        end
                    end
                    if (sclk_fall) begin
                        next_dout = shift[23];
                    end
                end
            end
            LSP_ST_LOST: begin
                // wait for enable high with clock low before framing again
                if (fen_n_lvl && !sclk_lvl) begin
                    next_state = LSP_ST_IDLE;
                end
            end
            default: begin
                next_state = LSP_ST_IDLE;
            end
        endcase
        if (commit) begin
            case (len_target(count))
                2'h1: next_cfg = shift[7:0];
                2'h2: begin
                    next_ref_mode = shift[15:13];
                    next_ref_buf1 = shift[12:0];
                end
                2'h3: begin
                    next_main_reg = shift;
                    next_ref_buf2 = ref_buf1;
                end
                default: begin
                    if (count == '0) begin
                        next_ref_buf2 = ref_buf1;
                    end
                end
            endcase // other nonzero lengths store nothing
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state    <= LSP_ST_IDLE;
            shift    <= '0;
            count    <= '0;
            dout     <= 1'b0;
            cfg      <= LSP_CFG_RST;
            ref_mode <= LSP_MODE_RST;
            ref_buf1 <= LSP_RDIV_RST;
            ref_buf2 <= LSP_RDIV_RST;
            main_reg <= LSP_MAIN_RST;
        end else begin
            state    <= next_state;
            shift    <= next_shift;
            count    <= next_count;
            dout     <= next_dout;
            cfg      <= next_cfg;
            ref_mode <= next_ref_mode;
            ref_buf1 <= next_ref_buf1;
            ref_buf2 <= next_ref_buf2;
            main_reg <= next_main_reg;
        end
    end

    // ==========================================================
    // dividers; the reference side reads only the second buffer
    logic                    ref_pulse;
    logic                    fb_pulse;
    logic [LSP_FB_DIV_W-1:0] fb_ratio;
    logic [LSP_N_W-1:0]      n_val;
    logic [LSP_A_W-1:0]      a_val;

    assign n_val    = main_reg[LSP_N_LSB +: LSP_N_W];
    assign a_val    = main_reg[LSP_A_LSB +: LSP_A_W];
    assign fb_ratio = {n_val, 6'h00} + {12'h000, a_val};

    lsp_pulse_div #(.W(LSP_REF_DIV_W)) u_ref_div (
        .mclk    (mclk),
        .rstn    (rstn),
        .tick    (ref_tick),
        .divisor (ref_buf2),
        .pulse   (ref_pulse)
    );

    lsp_pulse_div #(.W(LSP_FB_DIV_W)) u_fb_div (
        .mclk    (mclk),
        .rstn    (rstn),
        .tick    (rf_tick),
        .divisor (fb_ratio),
        .pulse   (fb_pulse)
    );

    // ==========================================================
    // output routing, all registered
    logic [1:0] sel;
    logic       next_config_out;
    logic       ref_out;

    assign sel = {main_reg[LSP_SEL_HI_POS], main_reg[LSP_SEL_LO_POS]};
    // ratio 1 bypasses the counter and passes the reference level through
    assign ref_out = (ref_buf2 == 13'h0001) ? sync[3] : ref_pulse;

    always_comb begin
        case (sel)
            LSP_SEL_REF:  next_config_out = ref_out;
            LSP_SEL_FB:   next_config_out = fb_pulse;
            LSP_SEL_DOUT: next_config_out = dout;
            default:      next_config_out = cfg[LSP_PORT_POS];
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            config_out     <= 1'b0;
            open_drain_out <= 1'b0;
            open_drain_oe  <= 1'b1;
        end else begin
            config_out     <= next_config_out;
            open_drain_out <= 1'b0;
            open_drain_oe  <= ~cfg[LSP_OD_POS];
        end
    end

    // ==========================================================
    // checks
    a_cfg_commit: assert property (@(posedge mclk) disable iff (!rstn)
        commit && count == 6'h08 |=> cfg == $past(shift[7:0]))
        else $error("8-bit frame did not load config");
    a_ref_commit: assert property (@(posedge mclk) disable iff (!rstn)
        commit && count == 6'h10 |=> ref_buf1 == $past(shift[12:0])
            && ref_mode == $past(shift[15:13]) && ref_buf2 == $past(ref_buf2))
        else $error("16-bit frame load wrong");
    a_main_commit: assert property (@(posedge mclk) disable iff (!rstn)
        commit && count == 6'h18 |=> main_reg == $past(shift)
            && ref_buf2 == $past(ref_buf1))
        else $error("24-bit frame load wrong");
    a_empty_pulse: assert property (@(posedge mclk) disable iff (!rstn)
        commit && count == 6'h00 |=> ref_buf2 == $past(ref_buf1)
            && $stable(main_reg))
        else $error("empty pulse did not move buffer");
    a_hold_shift: assert property (@(posedge mclk) disable iff (!rstn)
        !commit |=> $stable(cfg) && $stable(main_reg) && $stable(ref_buf1))
        else $error("register changed without commit");
    a_odd_len: assert property (@(posedge mclk) disable iff (!rstn)
        commit && len_target(count) == 2'h0 |=> $stable(cfg)
            && $stable(main_reg) && $stable(ref_buf1))
        else $error("odd frame length changed a register");
    a_idle_ignore: assert property (@(posedge mclk) disable iff (!rstn)
        state == LSP_ST_IDLE && !fen_fall |=> $stable(shift) && count == 6'h00)
        else $error("shifted while enable high");
    a_shift_msb: assert property (@(posedge mclk) disable iff (!rstn)
        state == LSP_ST_SHIFT && sclk_rise && !fen_rise
            |=> shift == {$past(shift[22:0]), $past(sdata_lvl)})
        else $error("bad shift");
    a_dout_fall: assert property (@(posedge mclk) disable iff (!rstn)
        !(state == LSP_ST_SHIFT && sclk_fall) |=> $stable(dout))
        else $error("data out changed off falling edge");
    a_resync: assert property (@(posedge mclk) disable iff (!rstn)
        state == LSP_ST_LOST && fen_n_lvl && !sclk_lvl |=> state == LSP_ST_IDLE)
        else $error("no resync");
    a_port_mode: assert property (@(posedge mclk) disable iff (!rstn)
        sel == LSP_SEL_PORT |=> config_out == $past(cfg[LSP_PORT_POS]))
        else $error("port level wrong");
    a_od_level: assert property (@(posedge mclk) disable iff (!rstn)
        1'b1 |=> open_drain_oe == !$past(cfg[LSP_OD_POS]) && !open_drain_out)
        else $error("open drain wrong");

    // ==========================================================
    // routing, framing and reset checks
    a_ref_route: assert property (@(posedge mclk) disable iff (!rstn)
        sel == LSP_SEL_REF |=> config_out == $past(ref_out))
        else $error("reference route wrong");
    a_fb_route: assert property (@(posedge mclk) disable iff (!rstn)
        sel == LSP_SEL_FB |=> config_out == $past(fb_pulse))
        else $error("feedback route wrong");
    a_dout_route: assert property (@(posedge mclk) disable iff (!rstn)
        sel == LSP_SEL_DOUT |=> config_out == $past(dout))
        else $error("data out route wrong");
    a_dirty_rise: assert property (@(posedge mclk) disable iff (!rstn)
        state == LSP_ST_SHIFT && fen_rise && sclk_lvl |=> state == LSP_ST_LOST
            && $stable(cfg) && $stable(main_reg) && $stable(ref_buf1) && $stable(ref_buf2))
        else $error("rise with clock high was committed");
    a_frame_start: assert property (@(posedge mclk) disable iff (!rstn)
        state == LSP_ST_IDLE && fen_fall && !sclk_lvl |=> state == LSP_ST_SHIFT
            && count == 6'h00)
        else $error("frame did not start clean");
    a_count_cap: assert property (@(posedge mclk) disable iff (!rstn)
        count <= LSP_CNT_SAT)
        else $error("bit count past saturation");
    a_cfg_only: assert property (@(posedge mclk) disable iff (!rstn)
        commit && count == 6'h08 |=> $stable(main_reg) && $stable(ref_buf1)
            && $stable(ref_buf2))
        else $error("8-bit frame touched another register");
    a_reset_od: assert property (@(posedge mclk)
        !rstn |=> open_drain_oe && !open_drain_out)
        else $error("reset did not pull open drain low");
    a_reset_sel: assert property (@(posedge mclk)
        !rstn |=> sel == LSP_SEL_DOUT && config_out == 1'b0)
        else $error("reset did not select data out");
endmodule // lsp_serial_port

/* File: test/length_steered_serial_port_tb.sv */
// testbench: frames of every length against the serial control port
`timescale 1ns/1ns
module length_steered_serial_port_tb;
    import lsp_pkg::*;
    localparam int REF_PER = 8; // reference period, mclk cycles
    localparam int RF_PER  = 6; // rf period, mclk cycles
    logic        mclk;
    logic        rstn;
    logic        reference_input;
    logic        rf_input;
    lsp_serial_s pins;
    logic        config_out;
    logic        open_drain_out;
    logic        open_drain_oe;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          c;

    lsp_host_model #(.ENB_MIN(195 * RF_PER)) host_u (.mclk(mclk), .pins(pins));
    lsp_serial_port dut_u (
        .mclk(mclk), .rstn(rstn), .serial_pins(pins),
        .reference_input(reference_input), .rf_input(rf_input),
        .config_out(config_out), .open_drain_out(open_drain_out),
        .open_drain_oe(open_drain_oe));
    // ==========================================================
    // clocks: mclk plus free running reference and rf inputs
    initial mclk = 1'h0;
    always #50 mclk = ~mclk;
    initial begin
        reference_input = 1'h0;
        rf_input = 1'h0;
        #55;
        fork
            forever #(REF_PER * 50) reference_input = ~reference_input;
            forever #(RF_PER * 50) rf_input = ~rf_input;
        join
    end
    // ==========================================================
    // checking and closing
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // high cycles of the configurable output, pulses are one cycle wide
    task automatic pulses(input int n, output int k);
        k = 0;
        repeat (n) begin
            @(posedge mclk);
            #5;
            if (config_out === 1'h1) k++;
        end
    endtask
    // window edges may cut one period either way
    function automatic logic near(input int k, input int e);
        return (k >= e - 1) && (k <= e + 1);
    endfunction
    // hang guard, well above the roughly 50k cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            summarize();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        rstn = 1'h0;
        repeat (16) @(posedge mclk);
        #5;
        rstn = 1'h1;
        host_u.hc(4);
        chk("od enable", open_drain_oe, 1'h1);
        chk("od level", open_drain_out, 1'h0);
        chk("out reset", config_out, 1'h0);
        host_u.frame(32'h0080_0000, 32);
        chk("dout one", config_out, 1'h1);
        host_u.frame(32'hFF7F_FFFF, 32);
        chk("dout zero", config_out, 1'h0);
        host_u.start();
        host_u.bits(32'h03, 8);
        chk("od mid frame", open_drain_oe, 1'h1);
        host_u.stop();
        chk("od released", open_drain_oe, 1'h0);
        host_u.frame(32'h00_0000, 24);
        chk("port high", config_out, 1'h1);
        host_u.frame(32'h01, 8);
        chk("port low", config_out, 1'h0);
        chk("od still off", open_drain_oe, 1'h0);
        host_u.frame(32'h00, 8);
        chk("od pulled", open_drain_oe, 1'h1);
        host_u.idle();
        host_u.frame(32'h02, 8);
        chk("after idle", config_out, 1'h1);
        host_u.lost(32'h00, 7); // eighth rise comes with the clock high
        chk("lost frame", config_out, 1'h1);
        host_u.frame(32'h01, 8);
        chk("resync", config_out, 1'h0);
        chk("resync od", open_drain_oe, 1'h0);
        // mid-run reset: open drain pulled and data out selected again
        rstn = 1'h0;
        host_u.hc(4);
        rstn = 1'h1;
        host_u.hc(4);
        chk("od after reset", open_drain_oe, 1'h1);
        host_u.frame(32'h02, 8);
        chk("dout after reset", config_out, 1'h0);
        host_u.frame(32'hC0_0000, 24);
        pulses(800, c);
        chk("ref silent", c, 0);
        host_u.frame(32'h0005, 16);
        pulses(800, c);
        chk("ref buffered", c, 0);
        host_u.start();
        host_u.stop();
        pulses(800, c);
        chk("ref by 5", near(c, 800 / (5 * REF_PER)), 1'h1);
        host_u.frame(32'h000A, 16);
        host_u.frame(32'hC0_0000, 24);
        pulses(800, c);
        chk("ref by 10", near(c, 800 / (10 * REF_PER)), 1'h1);
        host_u.frame(32'h0001, 16);
        host_u.start();
        host_u.stop();
        pulses(800, c);
        chk("ref pass", near(c, 400), 1'h1);
        host_u.frame(32'h80_0041, 24);
        pulses(65 * RF_PER * 10, c);
        chk("fb by 65", near(c, 10), 1'h1);
        summarize();
    end
endmodule // length_steered_serial_port_tb

/* File: test/lsp_host_model.sv */
// host model: microcontroller side of the serial control port
`timescale 1ns/1ns
module lsp_host_model #(
    parameter int ENB_MIN = 1170 // enable level hold, mclk cycles
) (
    input  wire logic            mclk, // system clock
    output lsp_pkg::lsp_serial_s pins  // clock, data, frame enable
);
    import lsp_pkg::*;
    time t0;
    // ==========================================================
    // idle pins: clock low and enable high from time zero
    initial begin
        pins = '{sclk: 1'h0, sdata: 1'h0, frame_enable_n: 1'h1};
    end
    // ==========================================================
    // pin tasks, every change lands just after an mclk edge
    task automatic hc(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask
    // enable starts high and is taken low with clock low
    task automatic start();
        pins.frame_enable_n = 1'h0;
        t0 = $time;
        hc(6);
    endtask
    // data set while clock low, msb first
    task automatic bits(input logic [31:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            pins.sdata = d[i];
            hc(6);
            pins.sclk = 1'h1;
            hc(6);
            pins.sclk = 1'h0;
        end
        hc(6);
    endtask
    // low time padded out, so long frames and empty pulses both qualify
    task automatic stop();
        while ($time - t0 < ENB_MIN * 100) hc(1);
        pins.frame_enable_n = 1'h1;
        hc(1);
        pins.sdata = ~pins.sdata; // released line keeps no stale level
        hc(ENB_MIN);
    endtask
    task automatic frame(input logic [31:0] d, input int n);
        start();
        bits(d, n);
        stop();
    endtask
    // deliberate fault: enable raised while the clock is high
    task automatic lost(input logic [31:0] d, input int n);
        start();
        bits(d, n);
        pins.sclk = 1'h1;
        hc(6);
        pins.frame_enable_n = 1'h1;
        hc(6);
        pins.sclk = 1'h0;
        hc(ENB_MIN);
    endtask
    // clock edges with enable high, which the port must ignore
    task automatic idle();
        repeat (4) begin
            pins.sdata = ~pins.sdata;
            pins.sclk = 1'h1;
            hc(6);
            pins.sclk = 1'h0;
            hc(6);
        end
    endtask
endmodule // lsp_host_model
